// ==== sutw_device.sv ====
// two-wire serial shift unit, device end
//
// Implementation choice: strobed register access.
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - sda falling while scl high sets start
// - after start, hold scl low from fall
// - receiver shifts sda in on rising scl
// - eight bits overflow counter, scl held low
// - software presets counter 14 for acknowledge
// - direction bit picks who drives sda
// - bytes flow one way until stop/start
// - ack withheld or ends read
// - sda low if bit7 or port zero
// - master confirms scl went high
// - output changes on falling scl edge
// - start condition detector only in two-wire mode
// - external clock: both edges count
// - preset F gives edge interrupt
// - cpu write beats simultaneous shift
// - left shift, clock from selected source
// - output via latch, transparent first half
// - completed transfer copies into receive buffer
// - outside two-wire, scl edge sets start with software clock selected
// - start interrupt gated; write one clears
// - status layout: flags high, counter low
// - wrap flag on fifteen to zero
// - stop flag in two-wire, no interrupt
module sutw_device
   import sutw_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // register port
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   // system events
   input wire logic timerMatch,
   input wire logic globalIrqEnable,
   output logic startIrq,
   output logic wrapIrq,
   // link
   sutw_link_if.dev link
);
   import sutw_pkg::*;

   typedef struct packed {
      logic [7:0] shiftData;
      logic [7:0] recvBuf;
      logic outLatch;
      logic [3:0] edgeCount;
      logic startSeen;
      logic countWrap;
      logic stopSeen;
      logic startIe;
      logic wrapIe;
      logic [1:0] wireMode;
      sutw_cs_e clockSel;
      logic [3:0] pins;
      logic startHold;
      logic sclS1;
      logic sclS2;
      logic sclPrev;
      logic sdaS1;
      logic sdaS2;
      logic sdaPrev;
      logic [7:0] rdata;
   } sutw_dev_s;

   sutw_dev_s s;
   sutw_dev_s next_s;

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb
   begin
      logic twoWire;
      logic sclRise;
      logic sclFall;
      logic sdaRise;
      logic sdaFall;
      logic wrCtrl;
      logic wrStat;
      logic wrData;
      logic wrPins;
      logic swClk;
      logic swTog;
      logic shiftTick;
      logic cntTick;
      logic wrap;
      logic startEv;
      logic transparent;
      logic collision;
      twoWire = 1'b0;
      sclRise = 1'b0;
      sclFall = 1'b0;
      sdaRise = 1'b0;
      sdaFall = 1'b0;
      wrCtrl = 1'b0;
      wrStat = 1'b0;
      wrData = 1'b0;
      wrPins = 1'b0;
      swClk = 1'b0;
      swTog = 1'b0;
      shiftTick = 1'b0;
      cntTick = 1'b0;
      wrap = 1'b0;
      startEv = 1'b0;
      transparent = 1'b0;
      collision = 1'b0;
      next_s = s;

      // synchronisers
      next_s.sclS1 = link.scl;
      next_s.sclS2 = s.sclS1;
      next_s.sclPrev = s.sclS2;
      next_s.sdaS1 = link.sda;
      next_s.sdaS2 = s.sdaS1;
      next_s.sdaPrev = s.sdaS2;
      sclRise = s.sclS2 & ~s.sclPrev;
      sclFall = ~s.sclS2 & s.sclPrev;
      sdaRise = s.sdaS2 & ~s.sdaPrev;
      sdaFall = ~s.sdaS2 & s.sdaPrev;
      twoWire = s.wireMode[1];

      // register writes
      wrCtrl = wr && (addr == OFF_CTRL);
      wrStat = wr && (addr == OFF_STATUS);
      wrData = wr && (addr == OFF_DATA);
      wrPins = wr && (addr == OFF_PINS);
      swClk = wrCtrl & wdata[CR_CLK];
      swTog = wrCtrl & wdata[CR_TOG];
      if (wrCtrl)
      begin
         next_s.startIe = wdata[CR_START_IE];
         next_s.wrapIe = wdata[CR_WRAP_IE];
         next_s.wireMode = wdata[CR_WM_LO +: 2];
         next_s.clockSel = sutw_cs_e'(wdata[CR_CS_LO +: 2]);
      end
      if (wrPins)
      begin
         next_s.pins = wdata[3:0];
      end
      if (swTog)
      begin
         next_s.pins[PR_SCL_PORT] = ~s.pins[PR_SCL_PORT];
      end

      // clock source
      case (s.clockSel)
         CS_SOFT: shiftTick = swClk;
         CS_TIMER: shiftTick = timerMatch;
         CS_EXT_RISE: shiftTick = sclRise;
         CS_EXT_FALL: shiftTick = sclFall;
         default: shiftTick = 1'b0;
      endcase
      cntTick = s.clockSel[1] ? (sclRise | sclFall) : shiftTick;

      // edge counter
      if (wrStat)
      begin
         next_s.edgeCount = wdata[3:0];
      end
      else if (cntTick)
      begin
         next_s.edgeCount = s.edgeCount + 4'h1;
         wrap = (s.edgeCount == 4'hF);
      end

      // shift register
      if (wrData)
      begin
         next_s.shiftData = wdata;
      end
      else if (shiftTick)
      begin
         next_s.shiftData = {s.shiftData[6:0], s.sdaS2};
      end
      if (wrap)
      begin
         next_s.recvBuf = next_s.shiftData;
      end

      // output latch
      case (s.clockSel)
         CS_EXT_RISE: transparent = ~s.sclS2;
         CS_EXT_FALL: transparent = s.sclS2;
         default: transparent = 1'b1;
      endcase
      if (transparent)
      begin
         next_s.outLatch = next_s.shiftData[7];
      end

      // flags, set beats clear
      startEv = (twoWire & sdaFall & s.sclS2)
         | (~twoWire & (s.clockSel == CS_SOFT) & (sclRise | sclFall));
      next_s.startSeen = (s.startSeen & ~(wrStat & wdata[SR_START])) | startEv;
      next_s.countWrap = (s.countWrap & ~(wrStat & wdata[SR_WRAP])) | wrap;
      next_s.stopSeen = (s.stopSeen & ~(wrStat & wdata[SR_STOP]))
         | (twoWire & sdaRise & s.sclS2);
      next_s.startHold = next_s.startSeen & twoWire
         & (s.startHold | (s.startSeen & sclFall));
      collision = twoWire & (s.outLatch != s.sdaS2);

      // read data, one cycle later
      next_s.rdata = 8'h00;
      if (rd)
      begin
         case (addr)
            OFF_CTRL: next_s.rdata = {s.startIe, s.wrapIe, s.wireMode, s.clockSel, 2'b00};
            OFF_STATUS: next_s.rdata = {s.startSeen, s.countWrap, s.stopSeen,
               collision, s.edgeCount};
            OFF_DATA: next_s.rdata = s.shiftData;
            OFF_BUFFER: next_s.rdata = s.recvBuf;
            OFF_PINS: next_s.rdata = {4'h0, s.pins};
            default: next_s.rdata = 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s <= '0;
         s.shiftData <= RST_DATA;
         s.pins <= RST_PINS;
         s.sclS1 <= 1'b1;
         s.sclS2 <= 1'b1;
         s.sclPrev <= 1'b1;
         s.sdaS1 <= 1'b1;
         s.sdaS2 <= 1'b1;
         s.sdaPrev <= 1'b1;
      end
      else
      begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign rdata = s.rdata;
   assign startIrq = s.startSeen & s.startIe & globalIrqEnable;
   assign wrapIrq = s.countWrap & s.wrapIe & globalIrqEnable;
   assign link.devSclOut = 1'b0;
   assign link.devSdaOut = 1'b0;
   assign link.devSclOe = s.wireMode[1] & s.pins[PR_SCL_DDR]
      & (~s.pins[PR_SCL_PORT] | s.startHold | s.countWrap);
   assign link.devSdaOe = s.wireMode[1] & s.pins[PR_SDA_DDR]
      & (~s.outLatch | ~s.pins[PR_SDA_PORT]);
endmodule : sutw_device
`default_nettype wire

// ==== sutw_pkg.sv ====
// constants and types shared by both ends of the two-wire serial unit
`default_nettype none
package sutw_pkg;
   // device register offsets
   localparam logic [7:0] OFF_CTRL = 8'h0D;
   localparam logic [7:0] OFF_STATUS = 8'h0E;
   localparam logic [7:0] OFF_DATA = 8'h0F;
   localparam logic [7:0] OFF_BUFFER = 8'h10;
   localparam logic [7:0] OFF_PINS = 8'h11;
   // status fields
   localparam int SR_START = 7;
   localparam int SR_WRAP = 6;
   localparam int SR_STOP = 5;
   localparam int SR_COLL = 4;
   // control fields
   localparam int CR_START_IE = 7;
   localparam int CR_WRAP_IE = 6;
   localparam int CR_WM_LO = 4;
   localparam int CR_CS_LO = 2;
   localparam int CR_CLK = 1;
   localparam int CR_TOG = 0;
   // pin register fields
   localparam int PR_SDA_PORT = 0;
   localparam int PR_SCL_PORT = 1;
   localparam int PR_SDA_DDR = 2;
   localparam int PR_SCL_DDR = 3;
   // reset values
   localparam logic [7:0] RST_STATUS = 8'h00;
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_DATA = 8'h00;
   localparam logic [3:0] RST_PINS = 4'h3;
   // host register offsets and fields
   localparam logic [7:0] OFF_H_DRIVE = 8'h00;
   localparam logic [7:0] OFF_H_LINES = 8'h01;
   localparam logic [7:0] OFF_H_PULSE = 8'h02;
   localparam int HD_SCL_LOW = 0;
   localparam int HD_SDA_LOW = 1;
   localparam int HL_BUSY = 2;
   localparam int HL_RX = 3;
   // host clock pulse timing
   localparam int CLK_NS = 10;
   localparam int HALF_NS = 5000;
   localparam int HALF_CYC = (HALF_NS + CLK_NS - 1) / CLK_NS;
   // clock source selection
   typedef enum logic [1:0] {
      CS_SOFT = 2'h0,
      CS_TIMER = 2'h1,
      CS_EXT_RISE = 2'h2,
      CS_EXT_FALL = 2'h3
   } sutw_cs_e;
   // host pulse states
   typedef enum logic [1:0] {
      HS_IDLE = 2'h0,
      HS_WAIT_HIGH = 2'h1,
      HS_HIGH = 2'h2,
      HS_LOW = 2'h3
   } sutw_hs_e;
endpackage : sutw_pkg
`default_nettype wire

// ==== sutw_link_if.sv ====
// open-drain scl/sda link joining device end and host end
`timescale 1ns/1ns
`default_nettype none
interface sutw_link_if;
   logic devSclOut;
   logic devSclOe;
   logic devSdaOut;
   logic devSdaOe;
   logic hostSclOut;
   logic hostSclOe;
   logic hostSdaOut;
   logic hostSdaOe;
   wire scl;
   wire sda;
   // wired-and with pull-up
   assign scl = ~((devSclOe & ~devSclOut) | (hostSclOe & ~hostSclOut));
   assign sda = ~((devSdaOe & ~devSdaOut) | (hostSdaOe & ~hostSdaOut));
   modport dev (
      output devSclOut, devSclOe, devSdaOut, devSdaOe,
      input scl, sda
   );
   modport host (
      output hostSclOut, hostSclOe, hostSdaOut, hostSdaOe,
      input scl, sda
   );
endinterface : sutw_link_if
`default_nettype wire

// ==== sutw_host.sv ====
// two-wire bus master end, software-steered bit level
`timescale 1ns/1ns
`default_nettype none
module sutw_host
   import sutw_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // register port
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   // link
   sutw_link_if.host link
);
   import sutw_pkg::*;

   typedef struct packed {
      logic sclLow;
      logic sdaLow;
      sutw_hs_e state;
      logic [9:0] timer;
      logic rxBit;
      logic sclS1;
      logic sclS2;
      logic sdaS1;
      logic sdaS2;
      logic [7:0] rdata;
   } sutw_host_s;

   sutw_host_s s;
   sutw_host_s next_s;

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb
   begin
      logic busy;
      busy = 1'b0;
      next_s = s;
      next_s.sclS1 = link.scl;
      next_s.sclS2 = s.sclS1;
      next_s.sdaS1 = link.sda;
      next_s.sdaS2 = s.sdaS1;
      busy = (s.state != HS_IDLE);

      // direct line drive, start/stop/ack by software
      if (wr && (addr == OFF_H_DRIVE))
      begin
         if (!busy)
         begin
            next_s.sclLow = wdata[HD_SCL_LOW];
         end
         next_s.sdaLow = wdata[HD_SDA_LOW];
      end

      // one scl pulse
      case (s.state)
         HS_IDLE:
         begin
            if (wr && (addr == OFF_H_PULSE))
            begin
               next_s.sclLow = 1'b0;
               next_s.state = HS_WAIT_HIGH;
            end
         end
         HS_WAIT_HIGH:
         begin
            if (s.sclS2)
            begin
               next_s.rxBit = s.sdaS2;
               next_s.timer = 10'(HALF_CYC - 1);
               next_s.state = HS_HIGH;
            end
         end
         HS_HIGH:
         begin
            if (s.timer == 10'h000)
            begin
               next_s.sclLow = 1'b1;
               next_s.timer = 10'(HALF_CYC - 1);
               next_s.state = HS_LOW;
            end
            else
            begin
               next_s.timer = s.timer - 10'h001;
            end
         end
         HS_LOW:
         begin
            if (s.timer == 10'h000)
            begin
               next_s.state = HS_IDLE;
            end
            else
            begin
               next_s.timer = s.timer - 10'h001;
            end
         end
         default: next_s.state = HS_IDLE;
      endcase

      next_s.rdata = 8'h00;
      if (rd)
      begin
         case (addr)
            OFF_H_DRIVE: next_s.rdata = {6'h00, s.sdaLow, s.sclLow};
            OFF_H_LINES: next_s.rdata = {4'h0, s.rxBit, busy, s.sdaS2, s.sclS2};
            default: next_s.rdata = 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s <= '0;
         s.sclS1 <= 1'b1;
         s.sclS2 <= 1'b1;
         s.sdaS1 <= 1'b1;
         s.sdaS2 <= 1'b1;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign rdata = s.rdata;
   assign link.hostSclOut = 1'b0;
   assign link.hostSdaOut = 1'b0;
   assign link.hostSclOe = s.sclLow;
   assign link.hostSdaOe = s.sdaLow;
endmodule : sutw_host
`default_nettype wire

// ==== sutw_link_props.sv ====
// link assertions for the two-wire serial unit
`timescale 1ns/1ns
`default_nettype none
module sutw_link_props
(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // device drivers
   input wire logic devSclOut,
   input wire logic devSclOe,
   input wire logic devSdaOut,
   input wire logic devSdaOe,
   // host drivers
   input wire logic hostSclOut,
   input wire logic hostSclOe,
   input wire logic hostSdaOut,
   input wire logic hostSdaOe,
   // bus lines
   input wire logic scl,
   input wire logic sda
);
   logic armed;
   logic sdaPrev;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////
   // start seen, hold not yet applied
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         armed <= 1'b0;
         sdaPrev <= 1'b1;
      end
      else
      begin
         sdaPrev <= sda;
         armed <= (scl && sdaPrev && !sda) || (armed && !devSclOe);
      end
   end
   sequence sclFallAfterStart;
      armed && $fell(scl);
   endsequence
   sequence holdSoon;
      ##[1:8] devSclOe;
   endsequence
   ////////////////////////////////////////
   AST_DEV_SCL_OPEN: assert property (!devSclOut)
      else $error("device scl driven high");
   AST_DEV_SDA_OPEN: assert property (!devSdaOut)
      else $error("device sda driven high");
   AST_HOST_OPEN: assert property (!hostSclOut && !hostSdaOut)
      else $error("host line driven high");
   AST_START_HOLD: assert property (sclFallAfterStart |-> holdSoon)
      else $error("no scl hold after start");
   AST_HOLD_ON_LOW: assert property ($rose(devSclOe) |-> !$past(scl))
      else $error("scl hold began while high");
   AST_SDA_ON_LOW: assert property ($changed(devSdaOe) |-> !$past(scl))
      else $error("device sda changed while scl high");
   AST_HOST_WAIT: assert property ($rose(hostSclOe) |-> $past(scl))
      else $error("host pulled scl before seeing it high");
   AST_HOST_HIGH: assert property ($rose(scl) && !hostSclOe |-> !hostSclOe [*8])
      else $error("scl high phase too short");
endmodule : sutw_link_props
`default_nettype wire

// ==== tb_serial_unit_two_wire_slave.sv ====
// self-checking bench joining device end and host end over the link
`timescale 1ns/1ns
`default_nettype none
module tb_serial_unit_two_wire_slave;
   import sutw_pkg::*;
   typedef struct {string n; logic [7:0] v; logic [7:0] m;} sutw_exp_s;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] addr, wdata, dRdata, hRdata, b;
   logic dWr, dRd, hWr, hRd, chk, pend, pendHost, gie, startIrq, wrapIrq, tmr;
   int nMismatch = 0;
   int checked = 0;
   logic [31:0] seed = 32'h0000_0055;
   sutw_exp_s expQ[$];
   sutw_exp_s e;
   sutw_link_if link();
   always #5 clk = ~clk;
   sutw_device i_sutw_device (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(dWr),
      .rd(dRd), .rdata(dRdata), .timerMatch(tmr), .globalIrqEnable(gie),
      .startIrq(startIrq), .wrapIrq(wrapIrq), .link(link.dev));
   sutw_host i_sutw_host (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(hWr),
      .rd(hRd), .rdata(hRdata), .link(link.host));
   sutw_link_props i_sutw_link_props (.clk(clk), .nrst(nrst),
      .devSclOut(link.devSclOut), .devSclOe(link.devSclOe), .devSdaOut(link.devSdaOut),
      .devSdaOe(link.devSdaOe), .hostSclOut(link.hostSclOut), .hostSclOe(link.hostSclOe),
      .hostSdaOut(link.hostSdaOut), .hostSdaOe(link.hostSdaOe), .scl(link.scl),
      .sda(link.sda));
   ////////////////////////////////////////
   function automatic logic [7:0] nextRand();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : nextRand
   task automatic check(input string n, input logic [7:0] x, input logic [7:0] s);
      checked++;
      if (s !== x)
      begin
         nMismatch++;
         $display("Error %s expected %h seen %h", n, x, s);
      end
   endtask : check
   task automatic bus(input bit host, input bit w, input logic [7:0] a, input logic [7:0] d,
      input bit c);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      dWr <= w && !host;
      dRd <= !w && !host;
      hWr <= w && host;
      hRd <= !w && host;
      chk <= c;
      @(posedge clk);
      dWr <= 1'b0;
      dRd <= 1'b0;
      hWr <= 1'b0;
      hRd <= 1'b0;
   endtask : bus
   task automatic wr(input bit host, input logic [7:0] a, input logic [7:0] d);
      bus(host, 1'b1, a, d, 1'b0);
   endtask : wr
   task automatic rd(input bit host, input logic [7:0] a, input logic [7:0] v,
      input logic [7:0] m, input string n);
      expQ.push_back('{n, v, m});
      bus(host, 1'b0, a, 8'h00, 1'b1);
   endtask : rd
   task automatic waitIdle();
      for (int k = 0; k < 600; k++)
      begin
         bus(1'b1, 1'b0, OFF_H_LINES, 8'h00, 1'b0);
         #1;
         if (hRdata[HL_BUSY] === 1'b0)
         begin
            break;
         end
      end
      if (hRdata[HL_BUSY] !== 1'b0)
      begin
         nMismatch++;
         $display("Error host busy expected 0 seen %b", hRdata[HL_BUSY]);
         endOfTest();
      end
   endtask : waitIdle
   task automatic pulse();
      wr(1'b1, OFF_H_PULSE, 8'h00);
      waitIdle();
   endtask : pulse
   // timer compare pulse, optionally beside a data write
   task automatic tick(input bit w, input logic [7:0] d);
      @(posedge clk);
      addr <= OFF_DATA;
      wdata <= d;
      dWr <= w;
      tmr <= 1'b1;
      @(posedge clk);
      dWr <= 1'b0;
      tmr <= 1'b0;
   endtask : tick
   task automatic endOfTest();
      $display("checked %0d mismatches %0d", checked, nMismatch);
      if (nMismatch == 0 && checked > 0)
      begin
         $display("All checks passed");
      end
      else
      begin
         $display("Checks failed");
      end
      $finish;
   endtask : endOfTest
   ////////////////////////////////////////
   // read results against oldest note
   always @(posedge clk)
   begin
      if (pend)
      begin
         e = expQ.pop_front();
         check(e.n, e.v & e.m, (pendHost ? hRdata : dRdata) & e.m);
      end
      pend <= (dRd || hRd) && chk;
      pendHost <= hRd;
   end
   initial
   begin
      repeat (60000) @(posedge clk);
      nMismatch++;
      endOfTest();
   end
   initial
   begin
      {addr, wdata, dWr, dRd, hWr, hRd, chk, tmr} = '0;
      gie = 1'b1;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      rd(0, OFF_STATUS, 8'h00, 8'hFF, "status");
      rd(0, OFF_CTRL, 8'h00, 8'hFF, "ctrl");
      rd(0, OFF_PINS, {4'h0, RST_PINS}, 8'hFF, "pins");
      rd(0, 8'h20, 8'h00, 8'hFF, "unmapped");
      rd(1, OFF_H_LINES, 8'h03, 8'h07, "idle lines");
      $display("test reset done");
      wr(0, OFF_CTRL, 8'hE8);
      wr(0, OFF_PINS, 8'h0B);
      wr(0, OFF_DATA, 8'hFF);
      wr(1, OFF_H_DRIVE, 8'h02);
      repeat (8) @(posedge clk);
      rd(0, OFF_STATUS, 8'h80, 8'h80, "start flag");
      check("start irq", 8'h01, {7'h00, startIrq});
      wr(1, OFF_H_DRIVE, 8'h03);
      repeat (8) @(posedge clk);
      wr(1, OFF_H_PULSE, 8'h00);
      repeat (20) @(posedge clk);
      rd(1, OFF_H_LINES, 8'h04, 8'h05, "held scl");
      wr(0, OFF_STATUS, 8'h80);
      waitIdle();
      wr(0, OFF_STATUS, 8'h00);
      check("start irq clear", 8'h00, {7'h00, startIrq});
      $display("test start done");
      for (int n = 0; n < 2; n++)
      begin
         b = nextRand();
         gie <= (n == 0);
         for (int i = 7; i >= 0; i--)
         begin
            wr(1, OFF_H_DRIVE, {6'h00, ~b[i], 1'b1});
            pulse();
         end
         rd(0, OFF_STATUS, 8'h40, 8'h4F, "wrap");
         check("wrap irq", {7'h00, (n == 0)}, {7'h00, wrapIrq});
         rd(0, OFF_BUFFER, b, 8'hFF, "buffer");
         rd(0, OFF_DATA, b, 8'hFF, "shift data");
         wr(0, OFF_DATA, 8'h00);
         wr(0, OFF_PINS, 8'h0F);
         wr(0, OFF_STATUS, 8'h4E);
         wr(1, OFF_H_DRIVE, 8'h01);
         pulse();
         rd(1, OFF_H_LINES, 8'h00, 8'h08, "ack bit");
         rd(0, OFF_STATUS, 8'h40, 8'h4F, "ack wrap");
         wr(0, OFF_PINS, 8'h0B);
         wr(0, OFF_DATA, 8'hFF);
         wr(0, OFF_STATUS, 8'h40);
         $display("test byte done");
      end
      wr(1, OFF_H_DRIVE, 8'h03);
      repeat (8) @(posedge clk);
      wr(1, OFF_H_DRIVE, 8'h02);
      repeat (8) @(posedge clk);
      wr(1, OFF_H_DRIVE, 8'h00);
      repeat (8) @(posedge clk);
      rd(0, OFF_STATUS, 8'h20, 8'hA0, "stop flag");
      repeat (4) @(posedge clk);
      $display("test stop done");
      wr(0, OFF_CTRL, 8'h04);
      wr(0, OFF_STATUS, 8'hE0);
      tick(1'b1, 8'h81);
      tick(1'b0, 8'h00);
      rd(0, OFF_DATA, 8'h03, 8'hFF, "timer shift");
      rd(0, OFF_STATUS, 8'h02, 8'hFF, "timer count");
      gie <= 1'b1;
      wr(0, OFF_CTRL, 8'h48);
      wr(0, OFF_STATUS, 8'h0F);
      wr(1, OFF_H_DRIVE, 8'h01);
      repeat (8) @(posedge clk);
      rd(0, OFF_STATUS, 8'h40, 8'hFF, "edge wrap");
      check("edge irq", 8'h01, {7'h00, wrapIrq});
      wr(0, OFF_CTRL, 8'h00);
      wr(0, OFF_STATUS, 8'hC0);
      wr(1, OFF_H_DRIVE, 8'h00);
      repeat (8) @(posedge clk);
      wr(0, OFF_CTRL, 8'h02);
      rd(0, OFF_STATUS, 8'h81, 8'hFF, "edge start");
      rd(0, OFF_DATA, 8'h07, 8'hFF, "soft shift");
      $display("test modes done");
      endOfTest();
   end
endmodule : tb_serial_unit_two_wire_slave
`default_nettype wire
